// File: design/vdbg_params.svh
// register offsets, field positions, reset values and timing counts for the blanking generator
`ifndef VDBG_PARAMS_SVH
`define VDBG_PARAMS_SVH
`define VDBG_OFF_CTRL       4'h0
`define VDBG_OFF_FRMSZ      4'h1
`define VDBG_OFF_HORIZ_BLANK_OUT      4'h2
`define VDBG_OFF_VBS1       4'h3
`define VDBG_OFF_VBE1       4'h4
`define VDBG_OFF_VBIT1      4'h5
`define VDBG_OFF_STAT       4'h6
`define VDBG_MASK_POS2      32'h0fff0fff
`define VDBG_MASK_HORIZ_BLANK_OUT     32'h0fff8fff
`define VDBG_MASK_CTRL      32'h00000007
`define VDBG_MASK_VBIT      32'h0fff0fff
`define VDBG_RST_CTRL       32'h00000000
`define VDBG_RST_FRMSZ      32'h020d035a
`define VDBG_RST_HORIZ_BLANK_OUT      32'h00000000
`define VDBG_RST_VBS1       32'h00000000
`define VDBG_RST_VBE1       32'h00000000
`define VDBG_RST_VBIT1      32'h00000000
`define VDBG_HI_MSB         27
`define VDBG_HI_LSB         16
`define VDBG_LO_MSB         11
`define VDBG_LO_LSB         0
`define VDBG_HORIZ_BLANK_DELAY_EN_BIT      15
`define VDBG_HDLY_CLKS      3'h4
`define VDBG_EAV_WORD       10'h274
`define VDBG_SAV_WORD       10'h200
`define VDBG_FBIT           8
`define VDBG_VBIT           7
`endif

// File: design/vdbg_pkg.sv
// types shared by the blanking generator
package vdbg_pkg;
    typedef enum logic [2:0] {
        VDBG_BT656_8  = 3'h0,
        VDBG_BT656_10 = 3'h1,
        VDBG_RAW_8    = 3'h2,
        VDBG_RAW_10   = 3'h3,
        VDBG_YC_8     = 3'h4,
        VDBG_YC_10    = 3'h5,
        VDBG_RAW_16   = 3'h6,
        VDBG_RAW_20   = 3'h7
    } vdbg_mode_t;
    typedef struct packed {
        logic        code_valid;
        logic        code_is_sav;
        logic [9:0]  code_word;
    } vdbg_code_t;
    typedef enum logic [1:0] {
        VDBG_IDLE = 2'b01,
        VDBG_RESP = 2'b10
    } vdbg_bus_t;
endpackage : vdbg_pkg

// File: design/vdbg_blank_gen.sv
// horizontal and field 1 vertical blanking generator with timing code placement
`timescale 1ns/1ps
`include "vdbg_params.svh"
// How it works
// R1 - horizontal blank goes active when pixel counter equals start position, any mode
// R2 - in BT.656 and Y/C the end-of-active code is placed at start position
// R3 - horizontal blank goes inactive when pixel counter equals stop position
// R4 - in BT.656 and Y/C the start-of-active code is placed at stop position
// R5 - delay bit postpones blank release by 4 clocks, only in BT.656 and Y/C
// R6 - horizontal start and stop are 12-bit pixel counter values
// R7 - raw mode start and stop bound the blanked pixels of each line
// R8 - field 1 vertical blank asserts at start line and start pixel
// R9 - field 1 vertical blank deasserts at stop line and stop pixel
// R10 - vertical blank output is independent of embedded timing codes
// R11 - V bit in codes comes from separate field 1 vertical-bit register
// R12 - reserved register bits read zero and ignore writes
// R13 - field 1 start and stop hold 12-bit line and 12-bit pixel numbers
// R14 - pixel counter runs 0 to width-1, line counter 1 to height
// R15 - 3-bit mode field selects BT.656, raw and Y/C modes
// R16 - all comparisons run each pixel clock on current register values
module vdbg_blank_gen
    import vdbg_pkg::*;
#(
    parameter int CW = 12
) (
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rstn,
    // avalon-mm slave
    input  wire logic [3:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // video timing outputs
    output logic                   o_horiz_blank_out,
    output logic                   o_vert_blank_out,
    output vdbg_code_t             o_timing_code,
    output logic      [CW-1:0]     o_frame_pixel_counter,
    output logic      [CW-1:0]     o_frame_line_counter
);

    function automatic logic [31:0] vdbg_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return ((old_v & ~m) | (new_v & m)) & mask;
    endfunction : vdbg_merge

    function automatic logic vdbg_embedded(input vdbg_mode_t md);
        return (md == VDBG_BT656_8) || (md == VDBG_BT656_10) ||
               (md == VDBG_YC_8) || (md == VDBG_YC_10); // R15
    endfunction : vdbg_embedded

    // register file
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] frmsz_reg, frmsz_next;
    logic [31:0] horiz_blank_out_reg, horiz_blank_out_next;
    logic [31:0] vbs1_reg, vbs1_next;
    logic [31:0] vbe1_reg, vbe1_next;
    logic [31:0] vbit1_reg, vbit1_next;
    logic [31:0] rdata_reg, rdata_next;
    vdbg_bus_t   bus_reg, bus_next;
    logic        acc;

    assign acc = (i_avs_read || i_avs_write) && (bus_reg == VDBG_IDLE);

    // one wait cycle, answer on the second edge so read data is registered
    always_comb begin
        ctrl_next  = ctrl_reg;
        frmsz_next = frmsz_reg;
        horiz_blank_out_next = horiz_blank_out_reg;
        vbs1_next  = vbs1_reg;
        vbe1_next  = vbe1_reg;
        vbit1_next = vbit1_reg;
        rdata_next = rdata_reg;
        bus_next   = bus_reg;
        case (bus_reg)
            VDBG_IDLE: begin
                if (acc) begin
                    bus_next = VDBG_RESP;
                end
            end
            VDBG_RESP: begin
                bus_next = VDBG_IDLE;
            end
            default: begin
                bus_next = VDBG_IDLE;
            end
        endcase
        // write lands at the edge where the master sees waitrequest low
        if (i_avs_write && (bus_reg == VDBG_RESP)) begin
            case (i_avs_address)
                `VDBG_OFF_CTRL: begin
                    ctrl_next = vdbg_merge(ctrl_reg, i_avs_writedata, i_avs_byteenable,
                                           `VDBG_MASK_CTRL);
                end
                `VDBG_OFF_FRMSZ: begin
                    frmsz_next = vdbg_merge(frmsz_reg, i_avs_writedata, i_avs_byteenable,
                                            `VDBG_MASK_POS2);
                end
                `VDBG_OFF_HORIZ_BLANK_OUT: begin
                    horiz_blank_out_next = vdbg_merge(horiz_blank_out_reg, i_avs_writedata, i_avs_byteenable,
                                            `VDBG_MASK_HORIZ_BLANK_OUT); // R12
                end
                `VDBG_OFF_VBS1: begin
                    vbs1_next = vdbg_merge(vbs1_reg, i_avs_writedata, i_avs_byteenable,
                                           `VDBG_MASK_POS2); // R12
                end
                `VDBG_OFF_VBE1: begin
                    vbe1_next = vdbg_merge(vbe1_reg, i_avs_writedata, i_avs_byteenable,
                                           `VDBG_MASK_POS2); // R12
                end
                `VDBG_OFF_VBIT1: begin
                    vbit1_next = vdbg_merge(vbit1_reg, i_avs_writedata, i_avs_byteenable,
                                            `VDBG_MASK_VBIT);
                end
                default: begin
                end
            endcase
        end
        if (acc && i_avs_read) begin
            case (i_avs_address)
                `VDBG_OFF_CTRL:  rdata_next = ctrl_reg;
                `VDBG_OFF_FRMSZ: rdata_next = frmsz_reg;
                `VDBG_OFF_HORIZ_BLANK_OUT: rdata_next = horiz_blank_out_reg;
                `VDBG_OFF_VBS1:  rdata_next = vbs1_reg;
                `VDBG_OFF_VBE1:  rdata_next = vbe1_reg;
                `VDBG_OFF_VBIT1: rdata_next = vbit1_reg;
                `VDBG_OFF_STAT:  rdata_next = {o_vert_blank_out, o_horiz_blank_out, 2'h0,
                                               o_frame_line_counter,
                                               4'h0, o_frame_pixel_counter};
                default:         rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg  <= `VDBG_RST_CTRL;
            frmsz_reg <= `VDBG_RST_FRMSZ;
            horiz_blank_out_reg <= `VDBG_RST_HORIZ_BLANK_OUT;
            vbs1_reg  <= `VDBG_RST_VBS1;
            vbe1_reg  <= `VDBG_RST_VBE1;
            vbit1_reg <= `VDBG_RST_VBIT1;
            rdata_reg <= 32'h00000000;
            bus_reg   <= VDBG_IDLE;
        end else begin
            ctrl_reg  <= ctrl_next;
            frmsz_reg <= frmsz_next;
            horiz_blank_out_reg <= horiz_blank_out_next;
            vbs1_reg  <= vbs1_next;
            vbe1_reg  <= vbe1_next;
            vbit1_reg <= vbit1_next;
            rdata_reg <= rdata_next;
            bus_reg   <= bus_next;
        end
    end

    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (bus_reg != VDBG_RESP);
    assign o_avs_readdata    = rdata_reg;

    // field views
    vdbg_mode_t   mode;
    logic         embed;
    logic [CW-1:0] width, height, hstart, hstop, vsl, vsp, vel, vep, vbit_start, vbit_stop;
    assign mode       = vdbg_mode_t'(ctrl_reg[2:0]); // R15
    assign embed      = vdbg_embedded(mode);
    assign width      = frmsz_reg[`VDBG_LO_MSB:`VDBG_LO_LSB];
    assign height     = frmsz_reg[`VDBG_HI_MSB:`VDBG_HI_LSB];
    assign hstart     = horiz_blank_out_reg[`VDBG_LO_MSB:`VDBG_LO_LSB]; // R6
    assign hstop      = horiz_blank_out_reg[`VDBG_HI_MSB:`VDBG_HI_LSB]; // R6
    assign vsp        = vbs1_reg[`VDBG_LO_MSB:`VDBG_LO_LSB]; // R13
    assign vsl        = vbs1_reg[`VDBG_HI_MSB:`VDBG_HI_LSB]; // R13
    assign vep        = vbe1_reg[`VDBG_LO_MSB:`VDBG_LO_LSB]; // R13
    assign vel        = vbe1_reg[`VDBG_HI_MSB:`VDBG_HI_LSB]; // R13
    assign vbit_start = vbit1_reg[`VDBG_LO_MSB:`VDBG_LO_LSB];
    assign vbit_stop  = vbit1_reg[`VDBG_HI_MSB:`VDBG_HI_LSB];

    // timing state
    logic [CW-1:0] pix_reg, pix_next, line_reg, line_next;
    logic          hb_reg, hb_next, vb_reg, vb_next, vbit_reg, vbit_next;
    logic [2:0]    dly_reg, dly_next;
    vdbg_code_t    code_reg, code_next;
    logic          hit_start, hit_stop, use_dly;

    assign hit_start = (pix_reg == hstart);
    assign hit_stop  = (pix_reg == hstop);
    assign use_dly   = embed && horiz_blank_out_reg[`VDBG_HORIZ_BLANK_DELAY_EN_BIT]; // R5

    always_comb begin
        pix_next  = pix_reg;
        line_next = line_reg;
        hb_next   = hb_reg;
        vb_next   = vb_reg;
        vbit_next = vbit_reg;
        dly_next  = dly_reg;
        code_next = '0;
        // pixel 0..width-1, line 1..height
        if (pix_reg >= width - 1'b1) begin
            pix_next = '0; // R14
            if (line_reg >= height) begin
                line_next = {{(CW-1){1'b0}}, 1'b1}; // R14
            end else begin
                line_next = line_reg + 1'b1;
            end
        end else begin
            pix_next = pix_reg + 1'b1; // R14
        end
        // delay countdown ends blank four clocks after stop
        if (dly_reg != 3'h0) begin
            dly_next = dly_reg - 3'h1;
            if (dly_reg == 3'h1) begin
                hb_next = 1'b0; // R5
            end
        end
        if (hit_stop) begin
            if (use_dly) begin
                dly_next = `VDBG_HDLY_CLKS; // R5
            end else begin
                hb_next = 1'b0; // R3 R7
            end
        end
        // start wins if start and stop coincide
        if (hit_start) begin
            hb_next  = 1'b1; // R1 R7
            dly_next = 3'h0;
        end
        // V bit tracks its own register, not the blanking ones
        if (line_reg == vbit_start) begin
            vbit_next = 1'b1; // R11
        end else if (line_reg == vbit_stop) begin
            vbit_next = 1'b0; // R11
        end
        if (line_reg == vel && pix_reg == vep) begin
            vb_next = 1'b0; // R9 R10
        end
        if (line_reg == vsl && pix_reg == vsp) begin
            vb_next = 1'b1; // R8 R10
        end
        if (embed && (hit_start || hit_stop)) begin
            code_next.code_valid  = 1'b1; // R2 R4
            code_next.code_is_sav = !hit_start; // R4
            code_next.code_word   = hit_start ? `VDBG_EAV_WORD : `VDBG_SAV_WORD; // R2
            code_next.code_word[`VDBG_VBIT] = vbit_reg; // R11
        end
    end

    // all timing updates on every pixel clock from live registers
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pix_reg  <= '0;
            line_reg <= {{(CW-1){1'b0}}, 1'b1};
            hb_reg   <= 1'b0;
            vb_reg   <= 1'b0;
            vbit_reg <= 1'b0;
            dly_reg  <= 3'h0;
            code_reg <= '0;
        end else begin
            pix_reg  <= pix_next; // R16
            line_reg <= line_next;
            hb_reg   <= hb_next;
            vb_reg   <= vb_next;
            vbit_reg <= vbit_next;
            dly_reg  <= dly_next;
            code_reg <= code_next;
        end
    end

    assign o_horiz_blank_out     = hb_reg;
    assign o_vert_blank_out      = vb_reg;
    assign o_timing_code         = code_reg;
    assign o_frame_pixel_counter = pix_reg;
    assign o_frame_line_counter  = line_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    hb_start_a: assert property (hit_start |=> o_horiz_blank_out) // R1
        else $error("hblank not set at start");
    hb_stop_a: assert property (hit_stop && !hit_start && !use_dly |=> !o_horiz_blank_out) // R3
        else $error("hblank not cleared at stop");
    hb_dly_a: assert property (hit_stop && !hit_start && use_dly && hb_reg
                               ##1 (!hit_start)[*4] |=> !o_horiz_blank_out) // R5
        else $error("delayed hblank release wrong");
    hb_dly_hold_a: assert property (hit_stop && !hit_start && use_dly && hb_reg
                                    |=> o_horiz_blank_out) // R5
        else $error("hblank released too early");
    eav_a: assert property (embed && hit_start |=> o_timing_code.code_valid
                            && !o_timing_code.code_is_sav) // R2
        else $error("eav missing");
    sav_a: assert property (embed && hit_stop && !hit_start |=> o_timing_code.code_is_sav) // R4
        else $error("sav missing");
    raw_nocode_a: assert property (!embed |=> !o_timing_code.code_valid) // R15
        else $error("code in raw mode");
    vb_start_a: assert property (line_reg == vsl && pix_reg == vsp |=> o_vert_blank_out) // R8
        else $error("vblank not set");
    vb_stop_a: assert property (line_reg == vel && pix_reg == vep && !(line_reg == vsl
                                && pix_reg == vsp) |=> !o_vert_blank_out) // R9
        else $error("vblank not cleared");
    pix_wrap_a: assert property (pix_reg >= width - 1'b1 && $stable(width)
                                 |=> pix_reg == '0) // R14
        else $error("pixel counter wrap wrong");
    rsvd_a: assert property (1'b1 |-> (horiz_blank_out_reg & ~`VDBG_MASK_HORIZ_BLANK_OUT) == 32'h0
                             && (vbs1_reg & ~`VDBG_MASK_POS2) == 32'h0) // R12
        else $error("reserved bits set");

    hb_cycle_c: cover property (hit_start ##[1:1000] hit_stop);
    dly_c: cover property (use_dly && hit_stop);
    vb_c: cover property (o_vert_blank_out ##1 !o_vert_blank_out);
    sav_c: cover property (o_timing_code.code_valid && o_timing_code.code_is_sav);

endmodule : vdbg_blank_gen

// File: sim/vdbg_disp_model.sv
// display-side monitor recording where blanking edges and timing codes land
`timescale 1ns/1ps
module vdbg_disp_model
    import vdbg_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // video from the generator
    input  wire logic        i_hblank,
    input  wire logic        i_vblank,
    input  wire vdbg_code_t  i_code,
    input  wire logic [11:0] i_pix,
    input  wire logic [11:0] i_line,
    // last events seen
    output logic      [11:0] o_ev [10],
    output int               o_code_cnt
);
    logic hb_reg;
    logic vb_reg;

    // 0/1 hblank on/off pixel, 2/3 eav/sav pixel, 4..7 vblank on line,pixel, off line,pixel,
    // 8/9 eav/sav word; a display only listens, so nothing is driven back
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hb_reg <= 1'b0;
            vb_reg <= 1'b0;
            o_code_cnt <= 0;
            for (int k = 0; k < 10; k++) o_ev[k] <= 12'hfff;
        end else begin
            hb_reg <= i_hblank;
            vb_reg <= i_vblank;
            if (i_hblank && !hb_reg) o_ev[0] <= i_pix;
            if (!i_hblank && hb_reg) o_ev[1] <= i_pix;
            if (i_vblank && !vb_reg) begin
                o_ev[4] <= i_line;
                o_ev[5] <= i_pix;
            end
            if (!i_vblank && vb_reg) begin
                o_ev[6] <= i_line;
                o_ev[7] <= i_pix;
            end
            if (i_code.code_valid) begin
                o_code_cnt <= o_code_cnt + 1;
                o_ev[i_code.code_is_sav ? 3 : 2] <= i_pix;
                o_ev[i_code.code_is_sav ? 9 : 8] <= {2'h0, i_code.code_word};
            end
        end
    end
endmodule : vdbg_disp_model

// File: sim/testbench.sv
// self-checking bench for the blanking generator
`timescale 1ns/1ps
`include "vdbg_params.svh"
module testbench;
    import vdbg_pkg::*;
    logic        i_ref_clk;
    logic        i_rstn;
    logic [3:0]  i_avs_address;
    logic        i_avs_read;
    logic        i_avs_write;
    logic [31:0] i_avs_writedata;
    logic [3:0]  i_avs_byteenable;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic        o_horiz_blank_out;
    logic        o_vert_blank_out;
    vdbg_code_t  o_timing_code;
    logic [11:0] o_frame_pixel_counter;
    logic [11:0] o_frame_line_counter;
    logic [11:0] ev [10];
    int          code_cnt;
    int          bad_count;
    int          samples_checked;
    int          n0;
    int          k;
    logic        emb;
    logic [11:0] mx_pix;
    logic [11:0] mx_line;
    logic [11:0] mn_line;
    logic [31:0] st;
    logic [31:0] msk [6] = '{32'h7, 32'h0fff0fff, 32'h0fff8fff, 32'h0fff0fff, 32'h0fff0fff,
                             `VDBG_MASK_VBIT};

    vdbg_blank_gen #(.CW(12)) vdbg_blank_gen_inst (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_horiz_blank_out(o_horiz_blank_out),
        .o_vert_blank_out(o_vert_blank_out), .o_timing_code(o_timing_code),
        .o_frame_pixel_counter(o_frame_pixel_counter), .o_frame_line_counter(o_frame_line_counter));

    vdbg_disp_model vdbg_disp_model_inst (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_hblank(o_horiz_blank_out),
        .i_vblank(o_vert_blank_out), .i_code(o_timing_code), .i_pix(o_frame_pixel_counter),
        .i_line(o_frame_line_counter), .o_ev(ev), .o_code_cnt(code_cnt));

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // waitrequest and read data are taken at the rising edge, before that edge's updates land
    task automatic bus(input logic rnw, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge i_ref_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_read <= rnw;
        i_avs_write <= !rnw;
        do @(posedge i_ref_clk); while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : reg_wr

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: word %h wanted %h", $time, got, exp);
        end
    endtask : cmp32

    task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: value %h wanted %h", $time, got, exp);
        end
    endtask : cmp12

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        cmp32(q, exp);
    endtask : rd_chk

    task automatic results;
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        #(40 * 20000);
        bad_count++;
        $display("unexpected at %0t: run hung", $time);
        results();
    end

    initial begin
        bad_count = 0;
        samples_checked = 0;
        i_rstn = 1'b0;
        i_avs_address = 4'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hf;
        repeat (10) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        @(negedge i_ref_clk);
        cmp12({11'h0, o_horiz_blank_out}, 12'h0);
        cmp12(o_frame_line_counter, 12'h1);
        rd_chk(`VDBG_OFF_CTRL, 32'h0);
        rd_chk(`VDBG_OFF_FRMSZ, `VDBG_RST_FRMSZ);
        rd_chk(`VDBG_OFF_HORIZ_BLANK_OUT, 32'h0);
        rd_chk(`VDBG_OFF_VBE1, 32'h0);
        rd_chk(4'hf, 32'h0);
        $display("test reset done");
        for (int a = 0; a < 6; a++) begin
            reg_wr(a[3:0], 32'hffffffff);
            rd_chk(a[3:0], msk[a]);
        end
        reg_wr(4'hf, 32'hffffffff);
        rd_chk(4'hf, 32'h0);
        reg_wr(`VDBG_OFF_VBIT1, 32'h0);
        $display("test reserved bits done");
        // 40 pixels by 6 lines keeps every frame short
        reg_wr(`VDBG_OFF_FRMSZ, 32'h00060028);
        repeat (100) @(negedge i_ref_clk);
        mx_pix = 12'h0;
        mx_line = 12'h0;
        mn_line = 12'hfff;
        repeat (500) begin
            @(negedge i_ref_clk);
            if (o_frame_pixel_counter > mx_pix) mx_pix = o_frame_pixel_counter;
            if (o_frame_line_counter > mx_line) mx_line = o_frame_line_counter;
            if (o_frame_line_counter < mn_line) mn_line = o_frame_line_counter;
        end
        cmp12(mx_pix, 12'd39);
        cmp12(mx_line, 12'd6);
        cmp12(mn_line, 12'd1);
        bus(1'b1, `VDBG_OFF_STAT, 32'h0, st);
        cmp32(st & 32'h3000f000, 32'h0);
        cmp12({11'h0, st[11:0] < 12'd40}, 12'h1);
        cmp12({11'h0, (st[27:16] >= 12'd1) && (st[27:16] <= 12'd6)}, 12'h1);
        $display("test counters done");
        // pass 8 is mode 0 with the delay bit clear
        for (int m = 0; m < 9; m++) begin
            reg_wr(`VDBG_OFF_CTRL, {29'h0, m[2:0]});
            reg_wr(`VDBG_OFF_HORIZ_BLANK_OUT, (m == 8) ? 32'h0005001e : 32'h0005801e);
            repeat (2) @(negedge i_ref_clk);
            n0 = code_cnt;
            repeat (100) @(negedge i_ref_clk);
            emb = (m[1] == 1'b0);
            cmp12(ev[0], 12'd31);
            cmp12(ev[1], (emb && m < 8) ? 12'd10 : 12'd6);
            cmp12({11'h0, code_cnt > n0}, {11'h0, emb});
            if (emb) begin
                cmp12(ev[2], 12'd31);
                cmp12(ev[3], 12'd6);
                cmp12(ev[8], 12'h274);
                cmp12(ev[9], 12'h200);
            end
        end
        $display("test horizontal modes done");
        reg_wr(`VDBG_OFF_VBS1, 32'h0002000a);
        reg_wr(`VDBG_OFF_VBE1, 32'h00040014);
        repeat (300) @(negedge i_ref_clk);
        cmp12(ev[4], 12'd2);
        cmp12(ev[5], 12'd11);
        cmp12(ev[6], 12'd4);
        cmp12(ev[7], 12'd21);
        cmp12(ev[8], 12'h274);
        $display("test vertical blank done");
        reg_wr(`VDBG_OFF_VBIT1, 32'h00050003);
        // one line of margin so a code built before the write is not taken
        repeat (40) @(negedge i_ref_clk);
        k = 0;
        do begin
            @(negedge i_ref_clk);
            k++;
        end while (!(o_timing_code.code_valid === 1'b1 && o_timing_code.code_is_sav === 1'b0
                     && o_frame_line_counter === 12'd3) && k < 300);
        cmp12({2'h0, o_timing_code.code_word}, 12'h2f4);
        $display("test v bit done");
        results();
    end
endmodule : testbench
